// ### ccc_pkg.sv
package ccc_pkg;

  // ------------------------------------------------------------
  // Widths and sizes
  // ------------------------------------------------------------
  localparam int unsigned WC_WIDTH = 16;
  localparam int unsigned ADDR_WIDTH = 32;
  localparam int unsigned NUM_GLOBAL = 4;

  // ------------------------------------------------------------
  // Sweep extents and step sizes
  // ------------------------------------------------------------
  localparam logic [15:0] L1D_LINES = 16'h0200;
  localparam logic [15:0] L2_LINES = 16'h4000;
  localparam logic [15:0] WORDS_PER_LINE = 16'h0010;
  localparam logic [15:0] GLOBAL_STEP = 16'h0001;
  localparam logic [31:0] LINE_BYTES = 32'h0000_0040;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

  // ------------------------------------------------------------
  // Global register index, one per whole-cache operation
  // ------------------------------------------------------------
  localparam int unsigned GL_L1D_INV = 0;
  localparam int unsigned GL_L1D_WRITEBACK_INVALIDATE_OP = 1;
  localparam int unsigned GL_L2_INV = 2;
  localparam int unsigned GL_L2_WRITEBACK_INVALIDATE_OP = 3;

  // ------------------------------------------------------------
  // Operation kinds driven to the cache arrays
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_NONE,
    OP_L1D_INV,
    OP_L1D_WRITEBACK_INVALIDATE_OP,
    OP_L2_INV,
    OP_L2_WRITEBACK_INVALIDATE_OP,
    OP_BLK_L1D_WRITEBACK_INVALIDATE_OP,
    OP_BLK_L2_WRITEBACK_INVALIDATE_OP
  } ccc_op_t;

endpackage

// ### ccc_sweep.sv
`timescale 1ns/1ps
`default_nettype none

// Down counter that tracks what is left of a coherence sweep
module ccc_sweep #(
  parameter int unsigned W = ccc_pkg::WC_WIDTH
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic load_in,
  input wire logic [W-1:0] load_value_in,
  input wire logic step_in,
  input wire logic [W-1:0] step_size_in,
  // Status
  output logic [W-1:0] count_out,
  output logic last_out
);

  typedef struct packed {
    logic [W-1:0] count;
  } ccc_sweep_state_t;

  ccc_sweep_state_t state_q;
  ccc_sweep_state_t state_d;

  // Final step saturates at zero so a short tail never wraps
  always_comb begin
    state_d = state_q;
    if (load_in) begin
      state_d.count = load_value_in;
    end else if (step_in) begin
      if (state_q.count <= step_size_in) begin
        state_d.count = '0;
      end else begin
        state_d.count = state_q.count - step_size_in;
      end
    end
  end

  // State register
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_q.count <= W'(ccc_pkg::COUNT_RESET);
    end else begin
      state_q <= state_d;
    end
  end

  assign count_out = state_q.count;
  assign last_out = (state_q.count <= step_size_in);

  // Load takes the given value on the next edge
  sweep_load_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    load_in |=> count_out == $past(load_value_in))
    else $error("sweep count did not load");

endmodule // ccc_sweep

`default_nettype wire

// ### ccc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Writing one to a global coherence register launches that whole-cache operation.
// - Bit zero of each global register reads one while its operation runs, zero after.
// - The block word count reaches zero exactly when the block operation completes.
// - A memory fence stalls the core until all memory work, coherence included, is done.
// - With L1 data frozen, an L1 data writeback-invalidate lets CPU traffic run alongside.

module ccc_ctrl #(
  parameter logic [15:0] L1D_LINES = ccc_pkg::L1D_LINES,
  parameter logic [15:0] L2_LINES = ccc_pkg::L2_LINES,
  parameter logic [15:0] WORDS_PER_LINE = ccc_pkg::WORDS_PER_LINE
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic rst_n_in,
  // Global coherence registers
  input wire logic [3:0] gl_wr_in,
  input wire logic [3:0] gl_wr_data_in,
  output logic [3:0] gl_status_out,
  // Block coherence registers
  input wire logic [31:0] blk_addr_in,
  input wire logic blk_l2_in,
  input wire logic blk_wc_wr_in,
  input wire logic [15:0] blk_wc_data_in,
  output logic [15:0] block_word_count_out,
  // Fence and CPU traffic
  input wire logic memory_fence_instruction_in,
  input wire logic mem_outstanding_in,
  input wire logic l1_freeze_in,
  output logic fence_stall_out,
  output logic cpu_mem_stall_out,
  // Cache array side
  output logic cache_op_valid_out,
  output logic [2:0] cache_op_out,
  output logic [31:0] cache_addr_out,
  input wire logic cache_ack_in
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    ccc_pkg::ccc_op_t op;
    logic [31:0] addr;
  } ccc_state_t;

  ccc_state_t state_q;
  ccc_state_t state_d;

  logic idle;
  logic is_block;
  logic step;
  logic last;
  logic load;
  logic [15:0] load_value;
  logic [15:0] step_size;
  logic [15:0] count;
  logic [3:0] gl_launch;

  assign idle = (state_q.op == ccc_pkg::OP_NONE);
  assign is_block = (state_q.op == ccc_pkg::OP_BLK_L1D_WRITEBACK_INVALIDATE_OP) ||
                    (state_q.op == ccc_pkg::OP_BLK_L2_WRITEBACK_INVALIDATE_OP);
  assign step = !idle && cache_ack_in;
  assign gl_launch = gl_wr_in & gl_wr_data_in;

  // ------------------------------------------------------------
  // Launch and sweep sequencing
  // ------------------------------------------------------------
  // Requests arriving while busy are dropped: one engine, no queue
  always_comb begin
    state_d = state_q;
    load = 1'b0;
    load_value = ccc_pkg::COUNT_RESET;
    step_size = is_block ? WORDS_PER_LINE : ccc_pkg::GLOBAL_STEP;
    case (state_q.op)
      ccc_pkg::OP_NONE: begin
        state_d.addr = ccc_pkg::ADDR_RESET;
        load = 1'b1;
        if (gl_launch[ccc_pkg::GL_L1D_INV]) begin
          state_d.op = ccc_pkg::OP_L1D_INV;
          load_value = L1D_LINES;
        end else if (gl_launch[ccc_pkg::GL_L1D_WRITEBACK_INVALIDATE_OP]) begin
          state_d.op = ccc_pkg::OP_L1D_WRITEBACK_INVALIDATE_OP;
          load_value = L1D_LINES;
        end else if (gl_launch[ccc_pkg::GL_L2_INV]) begin
          state_d.op = ccc_pkg::OP_L2_INV;
          load_value = L2_LINES;
        end else if (gl_launch[ccc_pkg::GL_L2_WRITEBACK_INVALIDATE_OP]) begin
          state_d.op = ccc_pkg::OP_L2_WRITEBACK_INVALIDATE_OP;
          load_value = L2_LINES;
        end else if (blk_wc_wr_in && (blk_wc_data_in != 16'h0000)) begin
          state_d.op = blk_l2_in ? ccc_pkg::OP_BLK_L2_WRITEBACK_INVALIDATE_OP : ccc_pkg::OP_BLK_L1D_WRITEBACK_INVALIDATE_OP;
          state_d.addr = blk_addr_in;
          load_value = blk_wc_data_in;
        end
      end
      default: begin
        if (step) begin
          state_d.addr = state_q.addr + ccc_pkg::LINE_BYTES;
          if (last) begin
            state_d.op = ccc_pkg::OP_NONE; // Done on the same edge count hits zero
          end
        end
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      state_q.op <= ccc_pkg::OP_NONE;
      state_q.addr <= ccc_pkg::ADDR_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // ------------------------------------------------------------
  // Remaining-work counter
  // ------------------------------------------------------------
  ccc_sweep #(
    .W(ccc_pkg::WC_WIDTH)
  ) u_sweep (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .load_in(load),
    .load_value_in(load_value),
    .step_in(step),
    .step_size_in(step_size),
    .count_out(count),
    .last_out(last)
  );

  // ------------------------------------------------------------
  // Status and stall outputs
  // ------------------------------------------------------------
  // Busy bits follow the running operation only
  always_comb begin
    gl_status_out = 4'h0;
    gl_status_out[ccc_pkg::GL_L1D_INV] = (state_q.op == ccc_pkg::OP_L1D_INV);
    gl_status_out[ccc_pkg::GL_L1D_WRITEBACK_INVALIDATE_OP] = (state_q.op == ccc_pkg::OP_L1D_WRITEBACK_INVALIDATE_OP);
    gl_status_out[ccc_pkg::GL_L2_INV] = (state_q.op == ccc_pkg::OP_L2_INV);
    gl_status_out[ccc_pkg::GL_L2_WRITEBACK_INVALIDATE_OP] = (state_q.op == ccc_pkg::OP_L2_WRITEBACK_INVALIDATE_OP);
  end

  // Global sweeps reuse the counter, so hide it from the word count view
  assign block_word_count_out = is_block ? count : 16'h0000;

  // Fence holds the core while anything is still in flight
  assign fence_stall_out = memory_fence_instruction_in && (!idle || mem_outstanding_in);

  // Frozen L1 data cannot be disturbed by CPU traffic, so it may run alongside
  assign cpu_mem_stall_out = !idle && !(l1_freeze_in &&
    ((state_q.op == ccc_pkg::OP_L1D_WRITEBACK_INVALIDATE_OP) ||
     (state_q.op == ccc_pkg::OP_BLK_L1D_WRITEBACK_INVALIDATE_OP)));

  assign cache_op_valid_out = !idle;
  assign cache_op_out = state_q.op;
  assign cache_addr_out = state_q.addr;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  launch_global_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    idle && gl_launch[ccc_pkg::GL_L2_WRITEBACK_INVALIDATE_OP] && (gl_launch[2:0] == 3'h0)
    |=> gl_status_out == 4'h8 && cache_op_valid_out)
    else $error("L2 writeback-invalidate did not launch");

  busy_clear_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    (gl_status_out != 4'h0) && !(cache_ack_in && last) |=> gl_status_out == $past(gl_status_out))
    else $error("global busy bit changed before completion");

  busy_fall_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    $fell(|gl_status_out) |-> $past(cache_ack_in) && $past(last))
    else $error("global busy bit fell without a final step");

  wc_zero_done_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    is_block && cache_ack_in && last |=> block_word_count_out == 16'h0000 && idle)
    else $error("word count and completion out of step");

  wc_step_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    is_block && cache_ack_in && !last
    |=> block_word_count_out == $past(block_word_count_out) - WORDS_PER_LINE)
    else $error("word count step wrong");

  fence_stall_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    memory_fence_instruction_in && (cache_op_valid_out || mem_outstanding_in) |-> fence_stall_out)
    else $error("fence did not stall");

  fence_release_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    fence_stall_out |-> memory_fence_instruction_in && (cache_op_valid_out || mem_outstanding_in))
    else $error("fence stalled with nothing outstanding");

  freeze_pass_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    l1_freeze_in && gl_status_out[ccc_pkg::GL_L1D_WRITEBACK_INVALIDATE_OP] |-> !cpu_mem_stall_out)
    else $error("CPU traffic stalled during frozen writeback-invalidate");

  unfrozen_stall_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    cache_op_valid_out && !l1_freeze_in |-> cpu_mem_stall_out)
    else $error("CPU traffic ran during unfrozen coherence operation");

  // A running operation keeps its kind until done, so late launches are dropped
  busy_drop_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !idle && !step |=> cache_op_valid_out && cache_op_out == $past(cache_op_out))
    else $error("launch taken while an operation was running");

  addr_step_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    step |=> cache_addr_out == $past(cache_addr_out) + ccc_pkg::LINE_BYTES)
    else $error("sweep address did not advance by one line");

  idle_quiet_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    !cache_op_valid_out |-> gl_status_out == 4'h0 && block_word_count_out == 16'h0000)
    else $error("status shown with no operation running");

  block_launch_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
    idle && blk_wc_wr_in && (blk_wc_data_in != 16'h0000) && (gl_launch == 4'h0)
    |=> block_word_count_out == $past(blk_wc_data_in) && cache_op_valid_out)
    else $error("block operation did not load its word count");

endmodule // ccc_ctrl

`default_nettype wire

// ### ccc_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none

module ccc_ctrl_test;
  // ----------------------------------------------------------
  // Stimulus, observation and bookkeeping
  // ----------------------------------------------------------
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [3:0] gl_wr_in = 4'h0, gl_wr_data_in = 4'h0;
  logic [31:0] blk_addr_in = 32'h0;
  logic blk_l2_in = 1'b0, blk_wc_wr_in = 1'b0, cache_ack_in = 1'b0;
  logic [15:0] blk_wc_data_in = 16'h0;
  logic memory_fence_instruction_in = 1'b0, mem_outstanding_in = 1'b0, l1_freeze_in = 1'b0;
  logic [3:0] gl_status_out;
  logic [15:0] block_word_count_out;
  logic fence_stall_out, cpu_mem_stall_out, cache_op_valid_out;
  logic [2:0] cache_op_out;
  logic [31:0] cache_addr_out;
  logic [15:0] words;
  logic [31:0] baddr;
  logic l2;
  int miscompares = 0, total_checks = 0, cycles = 0;

  // Short sweeps keep the run brief; expectations use the same counts
  ccc_ctrl #(.L1D_LINES(16'h0004), .L2_LINES(16'h0008)) ccc_ctrl_inst (
    .mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .gl_wr_in(gl_wr_in), .gl_wr_data_in(gl_wr_data_in), .gl_status_out(gl_status_out),
    .blk_addr_in(blk_addr_in), .blk_l2_in(blk_l2_in), .blk_wc_wr_in(blk_wc_wr_in),
    .blk_wc_data_in(blk_wc_data_in), .block_word_count_out(block_word_count_out),
    .memory_fence_instruction_in(memory_fence_instruction_in),
    .mem_outstanding_in(mem_outstanding_in), .l1_freeze_in(l1_freeze_in),
    .fence_stall_out(fence_stall_out), .cpu_mem_stall_out(cpu_mem_stall_out),
    .cache_op_valid_out(cache_op_valid_out), .cache_op_out(cache_op_out),
    .cache_addr_out(cache_addr_out), .cache_ack_in(cache_ack_in)
  );

  // 250 MHz clock
  initial begin
    forever #2 mclk_in = ~mclk_in;
  end

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Word count left after one acknowledged line step, never below zero
  function automatic logic [15:0] wc_after_step(input logic [15:0] w);
    return (w > ccc_pkg::WORDS_PER_LINE) ? w - ccc_pkg::WORDS_PER_LINE : 16'h0000;
  endfunction

  // Line steps needed to cover a word count, a short tail taking a whole step
  function automatic int lines_for(input logic [15:0] w);
    return (int'(w) + int'(ccc_pkg::WORDS_PER_LINE) - 1) / int'(ccc_pkg::WORDS_PER_LINE);
  endfunction

  // Zero writes and a zero word count must leave the engine idle
  task automatic idle_poke();
    @(posedge mclk_in);
    gl_wr_in <= 4'hf;
    gl_wr_data_in <= 4'h0;
    blk_wc_wr_in <= 1'b1;
    blk_wc_data_in <= 16'h0;
    @(posedge mclk_in);
    gl_wr_in <= 4'h0;
    blk_wc_wr_in <= 1'b0;
    #1;
    chk("idle status", 32'h0, gl_status_out);
    chk("idle valid", 32'h0, cache_op_valid_out);
  endtask

  // Follows one running operation edge by edge with random acks and
  // random noise on the launch, fence and freeze inputs, and on traffic in block runs; launches while busy must be dropped
  task automatic run_op(input logic [3:0] mask, input logic [2:0] op, input int lines,
                        input logic [31:0] addr, input logic [15:0] wc);
    int left;
    logic pend, a, busy, l1op;
    logic [31:0] ea;
    logic [15:0] ew;
    left = lines;
    pend = 1'b0;
    ea = addr;
    ew = wc;
    l1op = (op == 3'h2) || (op == 3'h5);
    while (left > 0) begin
      a = 1'($urandom);
      @(posedge mclk_in);
      cache_ack_in <= a;
      // Launch noise only while at least three steps remain, so it lands on a busy engine
      gl_wr_in <= (left > 2) ? 4'($urandom) : 4'h0;
      gl_wr_data_in <= 4'($urandom);
      blk_wc_wr_in <= (left > 2) ? 1'($urandom) : 1'b0;
      blk_wc_data_in <= 16'($urandom);
      memory_fence_instruction_in <= 1'($urandom);
      l1_freeze_in <= 1'($urandom);
      if (op > 3'h4) mem_outstanding_in <= 1'($urandom); // Global runs keep memory quiet
      #1;
      if (pend) begin
        left--;
        ea += ccc_pkg::LINE_BYTES;
        ew = wc_after_step(ew);
      end
      pend = a;
      busy = (left > 0);
      chk("status", busy ? mask : 4'h0, gl_status_out);
      chk("valid", busy, cache_op_valid_out);
      chk("word count", busy ? ew : 16'h0, block_word_count_out);
      if (busy) chk("op", op, cache_op_out);
      if (busy) chk("addr", ea, cache_addr_out);
      chk("fence stall", memory_fence_instruction_in & (busy | mem_outstanding_in),
          fence_stall_out);
      chk("cpu stall", busy & ~(l1_freeze_in & l1op), cpu_mem_stall_out);
    end
    @(posedge mclk_in);
    cache_ack_in <= 1'b0;
    memory_fence_instruction_in <= 1'b0;
    mem_outstanding_in <= 1'b0;
    l1_freeze_in <= 1'b0;
    repeat (16) @(posedge mclk_in); // Sixteen quiet cycles after completion
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    void'($urandom(77486));
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    #1;
    chk("reset status", 32'h0, gl_status_out);
    chk("reset count", 32'h0, block_word_count_out);
    for (int i = 0; i < 4; i++) begin
      idle_poke();
      @(posedge mclk_in);
      gl_wr_in <= 4'h1 << i; // Launch bit of one global register
      gl_wr_data_in <= 4'h1 << i;
      run_op(4'h1 << i, 3'(i + 1), (i < 2) ? 4 : 8, 32'h0, 16'h0);
      $display("global operation %0d finished", i);
    end
    // Two global launches and a block write at once: the lower global index
    // wins; a reset held two edges in mid-sweep must then clear every indication
    @(posedge mclk_in);
    gl_wr_in <= 4'hc;
    gl_wr_data_in <= 4'hc;
    blk_wc_wr_in <= 1'b1;
    blk_wc_data_in <= 16'h0020;
    @(posedge mclk_in);
    gl_wr_in <= 4'h0;
    blk_wc_wr_in <= 1'b0;
    rst_n_in <= 1'b0;
    #1;
    chk("priority status", 32'h4, gl_status_out);
    chk("priority count", 32'h0, block_word_count_out);
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    #1;
    chk("mid reset status", 32'h0, gl_status_out);
    chk("mid reset valid", 32'h0, cache_op_valid_out);
    chk("mid reset count", 32'h0, block_word_count_out);
    chk("mid reset cpu stall", 32'h0, cpu_mem_stall_out);
    $display("priority and mid-run reset finished");
    for (int k = 0; k < 8; k++) begin
      // Corner counts first: one word, one full line, one word past a line
      words = (k == 0) ? 16'h1 : (k == 1) ? 16'h10 : (k == 2) ? 16'h11 : 16'($urandom_range(64, 1));
      baddr = $urandom & 32'hffff_ffc0;
      l2 = (k < 2) ? k[0] : 1'($urandom); // Both targets among the corners
      idle_poke();
      @(posedge mclk_in);
      blk_addr_in <= baddr; // Start, freeze and traffic vary while it runs
      blk_l2_in <= l2;
      blk_wc_wr_in <= 1'b1;
      blk_wc_data_in <= words;
      run_op(4'h0, l2 ? 3'h6 : 3'h5, lines_for(words), baddr, words);
      $display("block operation %0d of %0d words finished", k, words);
    end
    tally_and_finish();
  end
endmodule // ccc_ctrl_test

`default_nettype wire
